// ==== hdl/cfgen_params.svh ====
// Constants for the comma-free test code generator.
// Assumes inclusion by the package and the generator module only.
`ifndef CFGEN_PARAMS_SVH
`define CFGEN_PARAMS_SVH

// Rates and ratios
`define CFG_SYMBOL_RATE       86400
`define CFG_WORD_BIT_RATE     16200
`define CFG_CYCLES_PER_SYMBOL 2'h3
`define CFG_DIV3_LAST         2'h2
`define CFG_SYMBOLS_PER_WORD  32
`define CFG_POS_LAST          5'h1F
`define CFG_DATA_BITS         6

// Register widths and seeds
`define CFG_WORD_SR_BITS      9
`define CFG_WORD_SEED         9'h001
`define CFG_WORD_TAP          4
`define CFG_VEC_SR_BITS       5
`define CFG_VEC_SEED          5'h11
`define CFG_VEC_TAP           2
`define CFG_VEC_FILL          1'h1

`endif

// ==== hdl/cfgen_pkg.sv ====
// Types for the comma-free test code generator.
// Assumes cfgen_params.svh is on the include path.
`include "cfgen_params.svh"

package cfgen_pkg;

	typedef struct packed {
		logic                          oscSync1;
		logic                          oscSync2;
		logic                          oscSync3;
		logic                          oscLevel;
		logic                          subcarrier;
		logic [1:0]                    div3;
		logic [4:0]                    position;
		logic [`CFG_WORD_SR_BITS-1:0]  wordShift;
		logic [`CFG_VEC_SR_BITS-1:0]   vectorShift;
		logic                          vectorFill;
		logic                          symbolPulse;
		logic                          wordPulse;
		logic                          bioSymbol;
		logic                          vectorSymbol;
		logic                          commaFreeSymbol;
		logic                          modulatedOut;
	} state_t;

endpackage

// ==== hdl/comma_free_test_code_generator.sv ====
// Digital core of a telemetry test signal generator: divider chain,
// data word source, biorthogonal and comma-free coding, subcarrier.
// Assumes a shaped oscillator pulse train on a pin, far slower than
// clk_sys (50 MHz), so that each pulse is seen as one high level.
`include "cfgen_params.svh"

module comma_free_test_code_generator (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Shaped oscillator pulses, asynchronous
	input  wire logic       oscPulse,
	// Timing outputs
	output logic            baseSubcarrierClock,
	output logic            symbolPulse,
	output logic            wordPulse,
	output logic [4:0]      symbolPosition,
	// Code outputs
	output logic [5:0]      dataWord,
	output logic            bioSymbol,
	output logic            vectorSymbol,
	output logic            commaFreeSymbol,
	output logic            modulatedOut
);
	import cfgen_pkg::*;

	cfgen_pkg::state_t st;
	cfgen_pkg::state_t next_st;

	// Checks below all run on the system clock, off during reset
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Table mapping: low five data bits select position bits, bit 5
	// adds the complemented position parity.
	function automatic logic bioCode(input logic [5:0] d,
		input logic [4:0] p);
		bioCode = (^(d[4:0] & p)) ^ (d[5] & ~(^p));
	endfunction

	logic baseTick;
	logic wordFeedback;
	logic vectorFeedback;

	always_comb begin
		next_st = st;
		// Second and third stages must agree before a change counts
		next_st.oscSync1 = oscPulse;
		next_st.oscSync2 = st.oscSync1;
		next_st.oscSync3 = st.oscSync2;
		if (st.oscSync2 == st.oscSync3) begin
			next_st.oscLevel = st.oscSync3;
		end
		// Base clock edge is the rising edge of the square wave
		baseTick = 1'b0;
		if (next_st.oscLevel && !st.oscLevel) begin
			next_st.subcarrier = ~st.subcarrier;
			baseTick = ~st.subcarrier;
		end
		next_st.symbolPulse = 1'b0;
		next_st.wordPulse = 1'b0;
		if (baseTick) begin
			if (st.div3 == `CFG_DIV3_LAST) begin
				next_st.div3 = 2'h0;
				next_st.symbolPulse = 1'b1;
			end else begin
				next_st.div3 = st.div3 + 2'h1;
			end
		end
		// Zero-state insertion turns the 511-state sequence into 512
		wordFeedback = st.wordShift[0] ^ st.wordShift[`CFG_WORD_TAP]
			^ (st.wordShift[`CFG_WORD_SR_BITS-1:1] == '0);
		vectorFeedback = st.vectorShift[0]
			^ st.vectorShift[`CFG_VEC_TAP];
		if (next_st.symbolPulse) begin
			next_st.position = st.position + 5'h1;
			if (st.position == `CFG_POS_LAST) begin
				next_st.wordPulse = 1'b1;
				next_st.wordShift = {wordFeedback,
					st.wordShift[`CFG_WORD_SR_BITS-1:1]};
			end else begin
				// Generator holds while the fill flop has position 31
				next_st.vectorShift = {vectorFeedback,
					st.vectorShift[`CFG_VEC_SR_BITS-1:1]};
			end
		end
		next_st.bioSymbol = bioCode(
			next_st.wordShift[`CFG_DATA_BITS-1:0],
			next_st.position);
		next_st.vectorSymbol = (next_st.position == `CFG_POS_LAST)
			? st.vectorFill : next_st.vectorShift[0];
		next_st.commaFreeSymbol = next_st.bioSymbol
			^ next_st.vectorSymbol;
		next_st.modulatedOut = next_st.subcarrier
			^ next_st.commaFreeSymbol;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.wordShift <= `CFG_WORD_SEED;
			st.vectorShift <= `CFG_VEC_SEED;
			st.vectorFill <= `CFG_VEC_FILL;
			st.vectorSymbol <= 1'h1;
			st.commaFreeSymbol <= 1'h1;
			st.modulatedOut <= 1'h1;
		end else begin
			st <= next_st;
		end
	end

	assign baseSubcarrierClock = st.subcarrier;
	assign symbolPulse = st.symbolPulse;
	assign wordPulse = st.wordPulse;
	assign symbolPosition = st.position;
	assign dataWord = st.wordShift[`CFG_DATA_BITS-1:0];
	assign bioSymbol = st.bioSymbol;
	assign vectorSymbol = st.vectorSymbol;
	assign commaFreeSymbol = st.commaFreeSymbol;
	assign modulatedOut = st.modulatedOut;

	// Checks
	a_square_toggle: assert property (
		st.oscLevel && !$past(st.oscLevel)
		|-> st.subcarrier != $past(st.subcarrier))
		else $error("square wave missed an oscillator pulse");

	a_symbol_rise: assert property (
		st.symbolPulse |-> st.subcarrier && !$past(st.subcarrier)
		&& st.div3 == 2'h0)
		else $error("symbol start not on subcarrier rising edge");

	a_div_three: assert property (
		$rose(st.subcarrier) |-> st.div3 == (($past(st.div3) == 2'h2)
		? 2'h0 : $past(st.div3) + 2'h1))
		else $error("divider left its range");

	a_pos_count: assert property (
		st.symbolPulse |-> st.position == $past(st.position) + 5'h1)
		else $error("position counter did not advance");

	a_word_start: assert property (
		st.wordPulse |-> st.symbolPulse && st.position == 5'h0)
		else $error("word pulse not at position zero");

	a_word_shift: assert property (
		st.wordPulse |-> st.wordShift[7:0] == $past(st.wordShift[8:1]))
		else $error("data register did not shift downward");

	a_word_hold: assert property (
		!st.wordPulse |-> $stable(st.wordShift))
		else $error("data word changed without word pulse");

	a_bio_map: assert property (
		st.bioSymbol == bioCode(st.wordShift[5:0], st.position))
		else $error("biorthogonal symbol mismatch");

	a_vector_ends: assert property (
		st.position == 5'h1F || st.position == 5'h0 |-> st.vectorSymbol)
		else $error("vector first or last symbol not one");

	a_cf_xor: assert property (
		st.commaFreeSymbol == (st.bioSymbol ^ st.vectorSymbol))
		else $error("comma-free symbol mismatch");

	a_mod_xor: assert property (
		st.modulatedOut == (st.subcarrier ^ st.commaFreeSymbol))
		else $error("modulated output mismatch");

	a_cf_stable: assert property (
		!st.symbolPulse |-> $stable(st.commaFreeSymbol))
		else $error("comma-free symbol changed mid-symbol");

	a_div_hold: assert property (
		!$rose(st.subcarrier) |-> $stable(st.div3))
		else $error("divider moved without a subcarrier rise");

	a_div_range: assert property (
		st.div3 != 2'h3)
		else $error("divider reached its unused state");

	a_pulse_single: assert property (
		st.symbolPulse |=> !st.symbolPulse)
		else $error("symbol pulse longer than one cycle");

	a_pos_hold: assert property (
		!st.symbolPulse |-> $stable(st.position))
		else $error("position moved without a symbol pulse");

	// The fill flop covers position 31, so the generator skips that step
	a_vec_hold: assert property (
		!st.symbolPulse || st.position == 5'h00
		|-> $stable(st.vectorShift))
		else $error("vector generator stepped out of turn");

	a_vec_live: assert property (
		st.vectorShift != 5'h00)
		else $error("vector generator locked at zero");

	a_bio_zero: assert property (
		st.wordShift[5:0] == 6'h00 |-> !st.bioSymbol)
		else $error("data zero did not give all-zero symbols");

	a_bio_one: assert property (
		st.wordShift[5:0] == 6'h01 |-> st.bioSymbol == st.position[0])
		else $error("data one did not give alternating symbols");

	a_sync_agree: assert property (
		$changed(st.oscLevel)
		|-> $past(st.oscSync2) == $past(st.oscSync3)
		&& st.oscLevel == $past(st.oscSync3))
		else $error("pin level taken before its stages agreed");

	a_sub_cause: assert property (
		$changed(st.subcarrier) |-> $rose(st.oscLevel))
		else $error("square wave moved without an oscillator pulse");

	// Subcarrier is high at a symbol start, so the output is inverted
	a_mod_start: assert property (
		st.symbolPulse |-> st.modulatedOut != st.commaFreeSymbol)
		else $error("symbol did not start on a high subcarrier half");

endmodule

// ==== tb/subcarrier_demod_model.sv ====
// Far-side model: subcarrier demodulator fed by the generator.
// Assumes it sees the generator outputs on the same system clock.
module subcarrier_demod_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Modulated stream and timing
	input  wire logic       subcarrier,
	input  wire logic       modulated,
	input  wire logic       symbolPulse,
	// Recovered symbol and subcarrier rises in the last symbol
	output logic            symbol,
	output logic [3:0]      risesSeen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prevSub;
	// Stripping the subcarrier recovers the code symbol
	assign symbol = modulated ^ subcarrier;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prevSub <= 1'h0;
			risesSeen <= 4'h0;
		end else begin
			prevSub <= subcarrier;
			// The pulse cycle holds the symbol's first rise
			if (symbolPulse)
				risesSeen <= 4'h1;
			else if (subcarrier && !prevSub)
				risesSeen <= risesSeen + 4'h1;
		end
	end
endmodule

// ==== tb/comma_free_test_code_generator_test.sv ====
// Self-checking bench for the comma-free test code generator.
// Assumes 8-clock oscillator pulses, so a symbol lasts 48 clocks.
module comma_free_test_code_generator_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] VEC = 32'h8DD425 << 8 | 32'h9F;
	logic clk_sys, rst, oscPulse, baseSubcarrierClock, symbolPulse;
	logic wordPulse, bioSymbol, vectorSymbol, commaFreeSymbol;
	logic modulatedOut, demodSymbol, moved, first;
	logic [4:0] symbolPosition, pos;
	logic [5:0] dataWord;
	logic [3:0] risesSeen;
	logic [8:0] w;
	int n_errors, comparisons, cycles, gap;

	comma_free_test_code_generator dut_u (.clk_sys, .rst, .oscPulse,
		.baseSubcarrierClock, .symbolPulse, .wordPulse, .symbolPosition,
		.dataWord, .bioSymbol, .vectorSymbol, .commaFreeSymbol,
		.modulatedOut);
	subcarrier_demod_model far_u (.clk_sys, .rst,
		.subcarrier(baseSubcarrierClock), .modulated(modulatedOut),
		.symbolPulse, .symbol(demodSymbol), .risesSeen);

	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic results();
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic test_reset();
		rst = 1'h1;
		repeat (3) @(negedge clk_sys);
		check("reset timing", 16'h0001, {baseSubcarrierClock, symbolPulse,
			wordPulse, symbolPosition, dataWord});
		check("reset codes", 16'h0007, {bioSymbol, vectorSymbol,
			commaFreeSymbol, modulatedOut});
		rst = 1'h0;
		{pos, w, first} = {5'h01, 9'h001, 1'h1};
	endtask

	task automatic wait_symbol();
		logic held;
		held = commaFreeSymbol;
		{gap, moved} = 0;
		do begin
			@(negedge clk_sys);
			gap++;
			if (symbolPulse !== 1'h1)
				moved |= commaFreeSymbol !== held;
		end while (symbolPulse !== 1'h1 && gap < 200);
	endtask

	task automatic test_words(int n);
		logic expBio, expCf;
		repeat (n * 32) begin
			wait_symbol();
			check("symbol pulse", 1, symbolPulse);
			check("subcarrier", 1, baseSubcarrierClock);
			check("position", pos, symbolPosition);
			check("word pulse", pos == 0, wordPulse);
			if (!first) check("symbol clocks", 48, gap);
			if (!first) check("rises", 3, risesSeen);
			if (pos == 0) w = {w[0] ^ w[4] ^ (w[8:1] == 8'h00), w[8:1]};
			expBio = ^(w[4:0] & pos) ^ (w[5] & ~^pos);
			expCf = expBio ^ VEC[31 - pos];
			check("data word", w[5:0], dataWord);
			check("vector", VEC[31 - pos], vectorSymbol);
			check("bio", expBio, bioSymbol);
			check("comma free", expCf, commaFreeSymbol);
			check("demod", expCf, demodSymbol);
			check("modulated", !expCf, modulatedOut);
			check("hold", 0, moved);
			{pos, first} = {pos + 5'h01, 1'h0};
		end
	endtask

	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end

	initial begin
		oscPulse = 1'h0;
		forever begin
			repeat (4) @(negedge clk_sys);
			oscPulse = ~oscPulse;
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			results();
		end
	end

	initial begin
		test_reset();
		test_words(8);
		repeat (5) wait_symbol();
		// Reset again mid-word, then restart the word sequence
		test_reset();
		test_words(2);
		results();
	end
endmodule
